/* File: rtl/extdec_pkg.sv */
package extdec_pkg;
    // Opcode upper bytes, the full call word and the second-word prefix nibble
    localparam logic [7:0] OP_PTR_ADD = 8'he8;
    localparam logic [7:0] OP_PTR_SUB = 8'he9;
    localparam logic [7:0] OP_PUSH_LIT = 8'hea;
    localparam logic [7:0] OP_STACK_MOVE = 8'heb;
    localparam logic [15:0] OP_CALL_WORK_REG = 16'h0014;
    localparam logic [3:0] OP_SECOND_WORD = 4'hf;
    // Field positions
    localparam int SEL_HI = 7;
    localparam int SEL_LO = 6;
    localparam int LIT6_HI = 5;
    localparam int VARIANT_BIT = 7;
    localparam logic [1:0] SEL_PTR_TWO = 2'h3;
    // Reset values
    localparam logic [11:0] PTR_RESET = 12'h000;
    localparam logic [7:0] LIT_WIDTH_ZERO = 8'h00;

    typedef enum logic [1:0]
    {
        EXTDEC_IDLE = 2'b00,
        EXTDEC_RETURN = 2'b01,
        EXTDEC_CALL = 2'b10,
        EXTDEC_MOVE2 = 2'b11
    } extdec_state_e;
endpackage

/* File: rtl/extdec_top.sv */
`timescale 1ns/1ns
module extdec_top
(
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic EXT_CONFIG_BIT,
    input wire logic INSTR_VALID,
    input wire logic [15:0] INSTR_WORD,
    input wire logic [7:0] WORK_REG_IN,
    output logic INSTR_READY,
    output logic EXT_ACTIVE,
    output logic INDEXED_MODE,
    output logic STD_PASS,
    output logic [11:0] PTR0,
    output logic [11:0] PTR1,
    output logic [11:0] PTR2,
    output logic MEM_WE,
    output logic [11:0] MEM_WADDR,
    output logic [7:0] MEM_WDATA,
    output logic MEM_RE,
    output logic [11:0] MEM_RADDR,
    output logic RETURN_REQ,
    output logic CALL_REQ,
    output logic [7:0] CALL_LOW,
    output logic FLAGS_WE
);
    // ==========================================================
    // Configuration capture
    // ==========================================================
    logic ext_en_q;
    logic [1:0] cfg_sync_q;
    // Config comes from fuses outside the clock, so synchronise it
    always_ff @(posedge CLK)
    begin
        if (!RSTN)
        begin
            cfg_sync_q <= 2'b00;
            ext_en_q <= 1'b0;
        end
        else
        begin
            cfg_sync_q <= {cfg_sync_q[0], EXT_CONFIG_BIT};
            ext_en_q <= cfg_sync_q[1];
        end
    end

    // Indexed literal offset mode rides on the same enable
    assign EXT_ACTIVE = ext_en_q;
    assign INDEXED_MODE = ext_en_q;
    assign FLAGS_WE = 1'b0;

    // ==========================================================
    // Decode
    // ==========================================================
    extdec_pkg::extdec_state_e state_q;
    extdec_pkg::extdec_state_e state_d;
    logic [7:0] hi;
    logic [1:0] sel;
    logic [11:0] lit6;
    logic take;
    logic is_add;
    logic is_sub;
    logic is_push;
    logic is_move;
    logic is_call;
    // Bookkeeping held between the two words of a stack move
    logic [11:0] move_src_q;
    logic move_var_q;

    // Field slices of the incoming word
    assign hi = INSTR_WORD[15:8];
    assign sel = INSTR_WORD[extdec_pkg::SEL_HI:extdec_pkg::SEL_LO];
    assign lit6 = {6'h00, INSTR_WORD[extdec_pkg::LIT6_HI:0]};

    // Ready stays high while a move waits for its second word
    assign INSTR_READY = (state_q == extdec_pkg::EXTDEC_IDLE) ||
                         (state_q == extdec_pkg::EXTDEC_MOVE2);
    assign take = INSTR_VALID && INSTR_READY && (state_q == extdec_pkg::EXTDEC_IDLE);
    // Only decoded while enabled; otherwise passed to the standard core
    assign is_add = ext_en_q && (hi == extdec_pkg::OP_PTR_ADD);
    assign is_sub = ext_en_q && (hi == extdec_pkg::OP_PTR_SUB);
    assign is_push = ext_en_q && (hi == extdec_pkg::OP_PUSH_LIT);
    assign is_move = ext_en_q && (hi == extdec_pkg::OP_STACK_MOVE);
    assign is_call = ext_en_q && (INSTR_WORD == extdec_pkg::OP_CALL_WORK_REG);
    assign STD_PASS = take && !(is_add || is_sub || is_push || is_move || is_call);

    // Sequencer
    // Returns and calls block one cycle so the fetch can flush
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            extdec_pkg::EXTDEC_IDLE:
            begin
                if (take && (is_add || is_sub) && sel == extdec_pkg::SEL_PTR_TWO)
                    state_d = extdec_pkg::EXTDEC_RETURN;
                else if (take && is_call)
                    state_d = extdec_pkg::EXTDEC_CALL;
                else if (take && is_move)
                    state_d = extdec_pkg::EXTDEC_MOVE2;
            end
            extdec_pkg::EXTDEC_RETURN: state_d = extdec_pkg::EXTDEC_IDLE;
            extdec_pkg::EXTDEC_CALL: state_d = extdec_pkg::EXTDEC_IDLE;
            extdec_pkg::EXTDEC_MOVE2:
            begin
                // Waits for second word; a bad prefix aborts quietly
                if (INSTR_VALID)
                    state_d = extdec_pkg::EXTDEC_IDLE;
            end
            default: state_d = extdec_pkg::EXTDEC_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge CLK)
    begin
        if (!RSTN)
            state_q <= extdec_pkg::EXTDEC_IDLE;
        else
            state_q <= state_d;
    end

    // ==========================================================
    // Pointer registers
    // ==========================================================
    // Pointer update: add/sub literal, push decrements pointer two
    always_ff @(posedge CLK)
    begin
        if (!RSTN)
        begin
            PTR0 <= extdec_pkg::PTR_RESET;
            PTR1 <= extdec_pkg::PTR_RESET;
            PTR2 <= extdec_pkg::PTR_RESET;
        end
        else if (take && is_add)
        begin
            // Select 11 falls to the default arm: pointer two
            case (sel)
                2'h0: PTR0 <= PTR0 + lit6;
                2'h1: PTR1 <= PTR1 + lit6;
                default: PTR2 <= PTR2 + lit6;
            endcase
        end
        else if (take && is_sub)
        begin
            case (sel)
                2'h0: PTR0 <= PTR0 - lit6;
                2'h1: PTR1 <= PTR1 - lit6;
                default: PTR2 <= PTR2 - lit6;
            endcase
        end
        // Push stores at the old pointer, then steps it down
        else if (take && is_push)
            PTR2 <= PTR2 - 12'h001;
    end

    // ==========================================================
    // Memory and control requests
    // ==========================================================
    // Registered so data outputs never glitch
    always_ff @(posedge CLK)
    begin
        if (!RSTN)
        begin
            MEM_WE <= 1'b0;
            MEM_WADDR <= extdec_pkg::PTR_RESET;
            MEM_WDATA <= extdec_pkg::LIT_WIDTH_ZERO;
            MEM_RE <= 1'b0;
            MEM_RADDR <= extdec_pkg::PTR_RESET;
            RETURN_REQ <= 1'b0;
            CALL_REQ <= 1'b0;
            CALL_LOW <= extdec_pkg::LIT_WIDTH_ZERO;
            move_src_q <= extdec_pkg::PTR_RESET;
            move_var_q <= 1'b0;
        end
        else
        begin
            MEM_WE <= 1'b0;
            MEM_RE <= 1'b0;
            RETURN_REQ <= (state_q == extdec_pkg::EXTDEC_RETURN);
            CALL_REQ <= (state_q == extdec_pkg::EXTDEC_CALL);
            if (take && is_call)
                CALL_LOW <= WORK_REG_IN;
            if (take && is_push)
            begin
                MEM_WE <= 1'b1;
                MEM_WADDR <= PTR2;
                MEM_WDATA <= INSTR_WORD[7:0];
            end
            if (take && is_move)
            begin
                move_src_q <= PTR2 + {5'h00, INSTR_WORD[6:0]};
                move_var_q <= INSTR_WORD[extdec_pkg::VARIANT_BIT];
                MEM_RE <= 1'b1;
                MEM_RADDR <= PTR2 + {5'h00, INSTR_WORD[6:0]};
            end
            if (state_q == extdec_pkg::EXTDEC_MOVE2 && INSTR_VALID &&
                INSTR_WORD[15:12] == extdec_pkg::OP_SECOND_WORD)
            begin
                MEM_WE <= 1'b1;
                // Variant 1 is pointer-relative, variant 0 an absolute address
                MEM_WADDR <= move_var_q ? (PTR2 + {5'h00, INSTR_WORD[6:0]})
                                        : INSTR_WORD[11:0];
                // Moved byte travels outside this block; zero stands in
                MEM_WDATA <= extdec_pkg::LIT_WIDTH_ZERO;
                MEM_RADDR <= move_src_q;
            end
        end
    end
endmodule

/* File: bench/extdec_properties.sv */
`timescale 1ns/1ns
// ====
// Port checks for the decoder
module extdec_properties
(
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic INSTR_VALID,
    input wire logic INSTR_READY,
    input wire logic [15:0] INSTR_WORD,
    input wire logic [7:0] WORK_REG_IN,
    input wire logic EXT_ACTIVE,
    input wire logic STD_PASS,
    input wire logic [11:0] PTR0,
    input wire logic [11:0] PTR2,
    input wire logic MEM_WE,
    input wire logic MEM_RE,
    input wire logic [7:0] MEM_WDATA,
    input wire logic RETURN_REQ,
    input wire logic CALL_REQ,
    input wire logic [7:0] CALL_LOW
);
    // Word taken while extension is live
    wire tk = INSTR_VALID & INSTR_READY & EXT_ACTIVE;
    wire [7:0] h = INSTR_WORD[15:8];
    wire [1:0] s = INSTR_WORD[7:6];
    default clocking @(posedge CLK); endclocking
    default disable iff (!RSTN);
    a_push_store: assert property (tk && h == 8'hea
        |=> MEM_WE && MEM_WDATA == $past(INSTR_WORD[7:0])) else $error("push data");
    a_push_dec: assert property (tk && h == 8'hea
        |=> PTR2 == $past(PTR2) - 12'h001) else $error("push pointer");
    a_add_ptr0: assert property (tk && h == 8'he8 && s == 2'h0
        |=> PTR0 == $past(PTR0) + $past(INSTR_WORD[5:0])) else $error("add pointer");
    a_addret_seq: assert property (tk && h == 8'he8 && s == 2'h3
        |=> !INSTR_READY ##1 RETURN_REQ) else $error("add return");
    a_subret_ptr: assert property (tk && h == 8'he9 && s == 2'h3
        |=> PTR2 == $past(PTR2) - $past(INSTR_WORD[5:0])) else $error("sub return");
    a_call_seq: assert property (tk && INSTR_WORD == 16'h0014
        |=> CALL_LOW == $past(WORK_REG_IN) ##1 CALL_REQ) else $error("call");
    a_off_inert: assert property (INSTR_VALID && INSTR_READY && !EXT_ACTIVE
        |-> STD_PASS) else $error("disabled pass");
    a_ext_claim: assert property (tk && h[7:2] == 6'h3a
        |-> !STD_PASS) else $error("extended pass");
    a_move_read: assert property (tk && h == 8'heb
        |=> MEM_RE) else $error("move read");
    a_reset_off: assert property ($rose(RSTN)
        |-> !EXT_ACTIVE && PTR2 == 12'h000) else $error("reset state");
    c_push: cover property (tk && h == 8'hea);
    c_move: cover property (tk && h == 8'heb);
    c_ret: cover property (RETURN_REQ);
    c_call: cover property (CALL_REQ);
endmodule

bind extdec_top extdec_properties u_props (.CLK(CLK), .RSTN(RSTN),
    .INSTR_VALID(INSTR_VALID), .INSTR_READY(INSTR_READY), .INSTR_WORD(INSTR_WORD),
    .WORK_REG_IN(WORK_REG_IN), .EXT_ACTIVE(EXT_ACTIVE), .STD_PASS(STD_PASS), .PTR0(PTR0),
    .PTR2(PTR2), .MEM_WE(MEM_WE), .MEM_RE(MEM_RE), .MEM_WDATA(MEM_WDATA),
    .RETURN_REQ(RETURN_REQ),
    .CALL_REQ(CALL_REQ), .CALL_LOW(CALL_LOW));

/* File: bench/extdec_mem.sv */
`timescale 1ns/1ns
// ====
// Data memory behind the pointers
module extdec_mem
(
    input wire logic clk,
    input wire logic we,
    input wire logic [11:0] waddr,
    input wire logic [7:0] wdata
);
    logic [7:0] m [4096];
    // Store on the edge the strobe is seen
    always_ff @(posedge clk)
    begin
        if (we)
            m[waddr] <= wdata;
    end
endmodule

/* File: bench/testbench.sv */
`timescale 1ns/1ns
module testbench;
    // ====
    // Stimulus, model and checks
    typedef struct {logic [15:0] w; logic [11:0] a, b, c;} extdec_row_s;
    logic CLK = 0, RSTN = 0, cfg = 0, vld = 0;
    logic [15:0] word = 16'h0000;
    logic [7:0] work_reg = 8'h7c;
    logic rdy, act, idx, pass, mwe, mre, ret, call, fwe;
    logic [11:0] p0, p1, p2, wa, ra;
    logic [7:0] wd, cl;
    int num_errors = 0, num_checks = 0;
    // Back-to-back single-cycle ops; last one pushes at 3f
    extdec_row_s rows [6] = '{'{16'he805, 12'h005, 12'h000, 12'h000},
        '{16'he84a, 12'h005, 12'h00a, 12'h000}, '{16'he8bf, 12'h005, 12'h00a, 12'h03f},
        '{16'he902, 12'h003, 12'h00a, 12'h03f}, '{16'he941, 12'h003, 12'h009, 12'h03f},
        '{16'hea5a, 12'h003, 12'h009, 12'h03e}};
    always #10 CLK = ~CLK;
    extdec_top dut (.CLK(CLK), .RSTN(RSTN), .EXT_CONFIG_BIT(cfg), .INSTR_VALID(vld),
        .INSTR_WORD(word), .WORK_REG_IN(work_reg), .INSTR_READY(rdy), .EXT_ACTIVE(act),
        .INDEXED_MODE(idx), .STD_PASS(pass), .PTR0(p0), .PTR1(p1), .PTR2(p2),
        .MEM_WE(mwe), .MEM_WADDR(wa), .MEM_WDATA(wd), .MEM_RE(mre), .MEM_RADDR(ra),
        .RETURN_REQ(ret), .CALL_REQ(call), .CALL_LOW(cl), .FLAGS_WE(fwe));
    extdec_mem mem (.clk(CLK), .we(mwe), .waddr(wa), .wdata(wd));
    task chk(input string n, input logic [11:0] s, input logic [11:0] e);
        num_checks++;
        if (s !== e)
        begin
            num_errors++;
            $display("MISMATCH %s exp %h seen %h", n, e, s);
        end
    endtask
    task end_sim;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Two-cycle op: ready drops, then the request pulse
    task t2(input logic [15:0] w, input bit c);
        word = w;
        vld = 1;
        @(negedge CLK);
        vld = 0;
        chk("ready", rdy, 0);
        @(negedge CLK);
        chk("request", c ? call : ret, 1);
    endtask
    // Hang guard, well past the sequence length
    initial
    begin
        #100000;
        num_errors++;
        end_sim;
    end
    initial
    begin
        repeat (12) @(negedge CLK);
        RSTN = 1;
        word = 16'he805;
        vld = 1;
        #1 chk("pass", pass, 1);
        @(negedge CLK);
        vld = 0;
        chk("p0 off", p0, 0);
        chk("active", act, 0);
        cfg = 1;
        repeat (4) @(negedge CLK);
        chk("active", act, 1);
        chk("indexed", idx, 1);
        foreach (rows[i])
        begin
            word = rows[i].w;
            vld = 1;
            @(negedge CLK);
            chk("p0", p0, rows[i].a);
            chk("p1", p1, rows[i].b);
            chk("p2", p2, rows[i].c);
        end
        vld = 0;
        @(negedge CLK);
        chk("pushed", mem.m[12'h03f], 12'h05a);
        t2(16'he8c3, 0);
        chk("p2 add", p2, 12'h041);
        t2(16'he9c1, 0);
        chk("p2 sub", p2, 12'h040);
        t2(16'h0014, 1);
        chk("call low", cl, 12'h07c);
        chk("flags", fwe, 0);
        // Stack-to-file move: read at p2+5, write to an absolute address
        word = 16'heb05;
        vld = 1;
        @(negedge CLK);
        chk("move re", mre, 1);
        chk("move ra", ra, 12'h045);
        chk("move rdy", rdy, 1);
        word = 16'hf123;
        @(negedge CLK);
        chk("move we", mwe, 1);
        chk("move wa", wa, 12'h123);
        // Stack-to-stack move: destination relative to p2
        word = 16'heb83;
        @(negedge CLK);
        chk("move ra", ra, 12'h043);
        word = 16'hf002;
        @(negedge CLK);
        chk("move wa", wa, 12'h042);
        // Second word without the prefix drops the move
        word = 16'heb01;
        @(negedge CLK);
        word = 16'h0000;
        @(negedge CLK);
        vld = 0;
        chk("move abort", mwe, 0);
        // Mid-run reset with the config bit cleared keeps the set off
        cfg = 0;
        RSTN = 0;
        repeat (3) @(negedge CLK);
        RSTN = 1;
        word = 16'hea11;
        vld = 1;
        #1 chk("pass off", pass, 1);
        @(negedge CLK);
        vld = 0;
        chk("active", act, 0);
        chk("p2 reset", p2, 0);
        chk("push off", mwe, 0);
        end_sim;
    end
endmodule
